// *** verilog/ptpu_policy.v ***
// port traffic policy unit: management vlan, unit settings, rate policing/shaping,
// and warm-start notice. assumes an upstream frame parser presents one frame header
// per valid strobe and a byte-count strobe per port; all inputs are on clk_i.
//
// Notes on behaviour
// RULE_01: management vlan only outside factory default mode
// RULE_02: tag option off: tag untagged management frames
// RULE_03: tag option on: pass only management vlan
// RULE_04: vid zero disables management on data ports
// RULE_05: data vlan maps need both ports tagged
// RULE_06: port pause only when unit pause enabled
// RULE_07: eight link-loss and remote-fault choices
// RULE_08: loopback, swap, multicast clear, no-learning settings
// RULE_09: maximum frame length 1518 to 12196 unit-wide
// RULE_10: priority below threshold low, else high
// RULE_11: warm-start notice after configured delay seconds
// RULE_12: per-port receive limit, zero means full
// RULE_13: receive stops at limit; pause before
// RULE_14: per-port transmit limit, zero means full
// RULE_15: transmit stops at limit; pause before buffers fill
// RULE_16: unit rate enable gates all limiting
// RULE_17: do not set receive and transmit limits together
// RULE_18: saved settings take effect after restart
`timescale 1ns/1ps
`include "ptpu_regs.vh"
module ptpu_policy #(
  parameter INTERVAL_CYC = `PTPU_INTERVAL_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire restart_i,
  input wire [2:0] sav_vlan_mode_i,
  input wire [11:0] sav_mgmt_vid_i,
  input wire sav_ext_tag_req_i,
  input wire sav_tag_a_i,
  input wire sav_tag_data_i,
  input wire sav_global_pause_i,
  input wire [2:0] sav_link_loss_sel_i,
  input wire [2:0] sav_loopback_i,
  input wire [13:0] sav_max_frame_i,
  input wire [2:0] sav_prio_thresh_i,
  input wire [7:0] sav_boot_delay_i,
  input wire sav_rate_en_i,
  input wire [31:0] sav_rx_lim_a_i,
  input wire [31:0] sav_rx_lim_d_i,
  input wire [31:0] sav_tx_lim_a_i,
  input wire [31:0] sav_tx_lim_d_i,
  input wire ext_frm_valid_i,
  input wire ext_frm_tagged_i,
  input wire [11:0] ext_frm_vid_i,
  input wire frm_valid_i,
  input wire [2:0] frm_prio_i,
  input wire [13:0] frm_len_i,
  input wire [1:0] rx_bytes_vld_i,
  input wire [13:0] rx_bytes_a_i,
  input wire [13:0] rx_bytes_d_i,
  input wire [1:0] tx_bytes_vld_i,
  input wire [13:0] tx_bytes_a_i,
  input wire [13:0] tx_bytes_d_i,
  input wire [1:0] tx_buf_near_full_i,
  input wire [1:0] port_pause_allow_i,
  output reg ext_pass_o,
  output reg ext_insert_tag_o,
  output reg [11:0] ext_vid_o,
  output reg mgmt_on_data_ports_o,
  output reg data_vlan_map_en_o,
  output reg frm_high_prio_o,
  output reg frm_too_long_o,
  output reg remote_fault_en_o,
  output reg fiber_loss_prop_en_o,
  output reg copper_loss_prop_en_o,
  output reg loop_en_o,
  output reg loop_swap_o,
  output reg loop_clear_mc_o,
  output reg learn_dis_o,
  output reg [1:0] rx_block_o,
  output reg [1:0] tx_block_o,
  output reg [1:0] pause_o,
  output reg warm_start_o
);

  // active settings: only copied from the saved set at restart [RULE_18]
  reg [2:0] vmode_q;
  reg [11:0] mvid_q;
  reg ext_tag_q;
  reg tag_a_q;
  reg tag_d_q;
  reg gpause_q;
  reg [2:0] lls_q;
  reg [2:0] lb_q;
  reg [13:0] maxf_q;
  reg [2:0] pth_q;
  reg [7:0] bdly_q;
  reg rate_q;
  reg [31:0] lim_q [0:3];

  // a restart pulse also clears counters and re-arms the warm-start delay
  reg [31:0] tick_cnt_q;
  reg sec_q;
  reg [7:0] sec_left_q;
  reg ws_pend_q;
  reg [31:0] used_q [0:3];
  // one loop index per process so no variable has two drivers
  integer i;
  integer j;
  integer k;

  // zero or the printed full value mean the full 1000 mbps byte budget
  function [31:0] budget;
    input [31:0] lim;
    input [31:0] full_alias;
    begin
      if (lim == 32'h0 || lim == full_alias || lim > `PTPU_FULL_RATE_BYTES)
        budget = `PTPU_FULL_RATE_BYTES;
      else
        budget = lim;
    end
  endfunction

  // clamp the frame limit into the legal window
  function [13:0] clamp_len;
    input [13:0] v;
    begin
      if (v < `PTPU_FRAME_MIN)
        clamp_len = `PTPU_FRAME_MIN;
      else if (v > `PTPU_FRAME_MAX)
        clamp_len = `PTPU_FRAME_MAX;
      else
        clamp_len = v;
    end
  endfunction

  // load defaults on reset and latch the saved configuration on restart
  always @(posedge clk_i) begin
    if (rst_i) begin
      vmode_q <= `PTPU_VMODE_DEFAULT;
      mvid_q <= 12'h000;
      ext_tag_q <= 1'b0;
      tag_a_q <= 1'b0;
      tag_d_q <= 1'b0;
      gpause_q <= 1'b0;
      lls_q <= 3'h0;
      lb_q <= `PTPU_LB_NORMAL;
      maxf_q <= `PTPU_FRAME_MIN;
      pth_q <= 3'h4;
      bdly_q <= 8'h00;
      rate_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        lim_q[i] <= 32'h0;
    end else if (restart_i) begin // [RULE_18]
      vmode_q <= sav_vlan_mode_i;
      // out-of-range ids are taken as zero, i.e. management off [RULE_04]
      mvid_q <= (sav_mgmt_vid_i > `PTPU_VID_MAX) ? 12'h000 : sav_mgmt_vid_i;
      ext_tag_q <= sav_ext_tag_req_i;
      tag_a_q <= sav_tag_a_i;
      tag_d_q <= sav_tag_data_i;
      gpause_q <= sav_global_pause_i;
      lls_q <= sav_link_loss_sel_i;
      // unknown loopback codes fall back to normal traffic
      lb_q <= (sav_loopback_i > `PTPU_LB_NOLEARN) ? `PTPU_LB_NORMAL : sav_loopback_i;
      maxf_q <= clamp_len(sav_max_frame_i); // [RULE_09]
      pth_q <= sav_prio_thresh_i;
      bdly_q <= sav_boot_delay_i;
      rate_q <= sav_rate_en_i;
      lim_q[0] <= budget(sav_rx_lim_a_i, `PTPU_RX_FULL_A); // [RULE_12]
      lim_q[1] <= budget(sav_rx_lim_d_i, `PTPU_RX_FULL_A);
      lim_q[2] <= budget(sav_tx_lim_a_i, `PTPU_TX_FULL_A); // [RULE_14]
      lim_q[3] <= budget(sav_tx_lim_d_i, `PTPU_TX_FULL_A);
    end
  end

  // external management port policy, registered per frame
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_pass_o <= 1'b0;
      ext_insert_tag_o <= 1'b0;
      ext_vid_o <= 12'h000;
    end else if (ext_frm_valid_i) begin
      ext_vid_o <= mvid_q;
      if (vmode_q == `PTPU_VMODE_DEFAULT) begin // [RULE_01]
        ext_pass_o <= 1'b1;
        ext_insert_tag_o <= 1'b0;
      end else if (ext_tag_q) begin
        ext_pass_o <= ext_frm_tagged_i && (ext_frm_vid_i == mvid_q); // [RULE_03]
        ext_insert_tag_o <= 1'b0;
      end else begin
        ext_pass_o <= 1'b1;
        ext_insert_tag_o <= !ext_frm_tagged_i && (mvid_q != 12'h000); // [RULE_02]
      end
    end
  end

  // frame classification for the data path
  always @(posedge clk_i) begin
    if (rst_i) begin
      frm_high_prio_o <= 1'b0;
      frm_too_long_o <= 1'b0;
    end else if (frm_valid_i) begin
      frm_high_prio_o <= (frm_prio_i >= pth_q); // [RULE_10]
      frm_too_long_o <= (frm_len_i > maxf_q); // [RULE_09]
    end
  end

  // static unit controls decoded from the active set
  always @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_on_data_ports_o <= 1'b0;
      data_vlan_map_en_o <= 1'b0;
      remote_fault_en_o <= 1'b0;
      fiber_loss_prop_en_o <= 1'b0;
      copper_loss_prop_en_o <= 1'b0;
      loop_en_o <= 1'b0;
      loop_swap_o <= 1'b0;
      loop_clear_mc_o <= 1'b0;
      learn_dis_o <= 1'b0;
    end else begin
      mgmt_on_data_ports_o <= (vmode_q != `PTPU_VMODE_DEFAULT) &&
                              (mvid_q != 12'h000); // [RULE_04] [RULE_01]
      data_vlan_map_en_o <= tag_a_q && tag_d_q; // [RULE_05]
      // three enable bits cover all eight choices [RULE_07]
      remote_fault_en_o <= lls_q[`PTPU_FA_REMOTE];
      fiber_loss_prop_en_o <= lls_q[`PTPU_FA_FIBER];
      copper_loss_prop_en_o <= lls_q[`PTPU_FA_COPPER];
      loop_en_o <= (lb_q == `PTPU_LB_PLAIN) || (lb_q == `PTPU_LB_SWAP) ||
                   (lb_q == `PTPU_LB_SWAP_MC); // [RULE_08]
      loop_swap_o <= (lb_q == `PTPU_LB_SWAP) || (lb_q == `PTPU_LB_SWAP_MC);
      loop_clear_mc_o <= (lb_q == `PTPU_LB_SWAP_MC);
      learn_dis_o <= (lb_q == `PTPU_LB_NOLEARN);
    end
  end

  // one-second tick; restart realigns the interval
  always @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      tick_cnt_q <= 32'h0;
      sec_q <= 1'b0;
    end else if (tick_cnt_q == INTERVAL_CYC - 1) begin
      tick_cnt_q <= 32'h0;
      sec_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      sec_q <= 1'b0;
    end
  end

  // byte usage per port and direction: 0 rx a, 1 rx data, 2 tx a, 3 tx data
  wire [3:0] cnt_vld;
  wire [13:0] cnt_by [0:3];
  assign cnt_vld = {tx_bytes_vld_i, rx_bytes_vld_i};
  assign cnt_by[0] = rx_bytes_a_i;
  assign cnt_by[1] = rx_bytes_d_i;
  assign cnt_by[2] = tx_bytes_a_i;
  assign cnt_by[3] = tx_bytes_d_i;

  // counters saturate so a long interval cannot wrap past the budget
  always @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      for (j = 0; j < 4; j = j + 1)
        used_q[j] <= 32'h0;
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (sec_q)
          used_q[j] <= 32'h0; // [RULE_13] [RULE_15]
        else if (cnt_vld[j] && used_q[j] < lim_q[j])
          used_q[j] <= used_q[j] + {18'h0, cnt_by[j]};
      end
    end
  end

  // block and pause; the margin raises pause before the cutoff
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_block_o <= 2'b00;
      tx_block_o <= 2'b00;
      pause_o <= 2'b00;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        // all limiting is off while the unit rate enable is clear [RULE_16]
        rx_block_o[k] <= rate_q && (used_q[k] >= lim_q[k]); // [RULE_13]
        tx_block_o[k] <= rate_q && (used_q[k+2] >= lim_q[k+2]); // [RULE_15]
        // pause needs unit and port permission [RULE_06]
        pause_o[k] <= gpause_q && port_pause_allow_i[k] &&
                      ((rate_q && (used_q[k] + `PTPU_PAUSE_MARGIN >= lim_q[k])) ||
                       tx_buf_near_full_i[k]); // [RULE_13] [RULE_15]
      end
    end
  end

  // warm-start notice after the configured whole seconds [RULE_11]
  always @(posedge clk_i) begin
    if (rst_i) begin
      ws_pend_q <= 1'b0;
      sec_left_q <= 8'h00;
      warm_start_o <= 1'b0;
    end else if (restart_i) begin
      ws_pend_q <= 1'b1;
      sec_left_q <= sav_boot_delay_i;
      warm_start_o <= 1'b0;
    end else if (ws_pend_q && sec_left_q == 8'h00) begin
      ws_pend_q <= 1'b0;
      warm_start_o <= 1'b1; // [RULE_11]
    end else begin
      warm_start_o <= 1'b0;
      if (ws_pend_q && sec_q)
        sec_left_q <= sec_left_q - 8'h01;
    end
  end

endmodule

// *** verilog/ptpu_regs.vh ***
// constants for the port traffic policy unit
// assumes a 10 MHz core clock and byte-granular frame length counting
`ifndef PTPU_REGS_VH
`define PTPU_REGS_VH
`define PTPU_CLK_HZ 32'd10000000
`define PTPU_INTERVAL_S 32'd1
`define PTPU_INTERVAL_CYC (`PTPU_CLK_HZ * `PTPU_INTERVAL_S)
`define PTPU_VID_MAX 12'hffe
`define PTPU_FRAME_MIN 14'd1518
`define PTPU_FRAME_MAX 14'd12196
`define PTPU_RX_FULL_A 32'd100000000
`define PTPU_TX_FULL_A 32'd1000000000
`define PTPU_FULL_RATE_BYTES 32'd125000000
`define PTPU_PAUSE_MARGIN 32'd16384
`define PTPU_VMODE_DEFAULT 3'h0
`define PTPU_LB_NORMAL 3'h0
`define PTPU_LB_PLAIN 3'h1
`define PTPU_LB_SWAP 3'h2
`define PTPU_LB_SWAP_MC 3'h3
`define PTPU_LB_NOLEARN 3'h4
`define PTPU_FA_REMOTE 0
`define PTPU_FA_FIBER 1
`define PTPU_FA_COPPER 2
`endif

// *** sim/ptpu_partner.sv ***
// link partner on port a: one receive byte-count strobe per go request
// assumes go_i and size_i are set by non-blocking assignment at the falling edge
`timescale 1ns/1ps
module ptpu_partner (
  input wire clk_i,
  input wire go_i,
  input wire [13:0] size_i,
  output reg vld_o,
  output reg [13:0] bytes_o
);
  initial begin
    vld_o = 1'b0;
    bytes_o = 14'h0;
  end
  // idle count lines toggle so a stale count is never mistaken for a strobe
  always @(negedge clk_i) begin
    vld_o <= go_i;
    bytes_o <= go_i ? size_i : ~bytes_o;
  end
endmodule

// *** sim/ptpu_checker.sv ***
// concurrent checks on the policy unit ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`include "ptpu_regs.vh"
module ptpu_checker #(
  parameter INTERVAL_CYC = `PTPU_INTERVAL_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire restart_i,
  input wire [7:0] sav_boot_delay_i,
  input wire [2:0] sav_loopback_i,
  input wire [2:0] sav_link_loss_sel_i,
  input wire [11:0] sav_mgmt_vid_i,
  input wire sav_global_pause_i,
  input wire sav_tag_a_i,
  input wire sav_tag_data_i,
  input wire sav_rate_en_i,
  input wire [1:0] rx_bytes_vld_i,
  input wire warm_start_o,
  input wire loop_en_o,
  input wire loop_swap_o,
  input wire loop_clear_mc_o,
  input wire remote_fault_en_o,
  input wire fiber_loss_prop_en_o,
  input wire copper_loss_prop_en_o,
  input wire mgmt_on_data_ports_o,
  input wire data_vlan_map_en_o,
  input wire ext_pass_o,
  input wire [1:0] rx_block_o,
  input wire [1:0] tx_block_o,
  input wire [1:0] pause_o
);
  // back-to-back restarts are not checked; the second one would overlap the window
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_warm_no_delay: assert property (restart_i && sav_boot_delay_i == 8'h0 |-> ##2 warm_start_o ##1 !warm_start_o) else $error("warm start pulse wrong");
  a_loop_swap_decode: assert property (restart_i && sav_loopback_i == `PTPU_LB_SWAP |-> ##2 loop_en_o && loop_swap_o && !loop_clear_mc_o) else $error("swap decode wrong");
  a_link_sel_decode: assert property (restart_i |-> ##2 {copper_loss_prop_en_o, fiber_loss_prop_en_o, remote_fault_en_o} == $past(sav_link_loss_sel_i, 2)) else $error("link loss decode wrong");
  a_pause_gate: assert property (restart_i && !sav_global_pause_i |-> ##2 pause_o == 2'h0) else $error("pause without unit enable");
  a_vlan_map_both: assert property (restart_i |-> ##2 data_vlan_map_en_o == $past(sav_tag_a_i && sav_tag_data_i, 2)) else $error("data vlan map gate wrong");
  a_mgmt_vid_zero: assert property (restart_i && sav_mgmt_vid_i == 12'h0 |-> ##2 !mgmt_on_data_ports_o) else $error("management left on");
  a_rate_off_free: assert property (restart_i && !sav_rate_en_i |-> ##2 rx_block_o == 2'h0 && tx_block_o == 2'h0) else $error("limit with rate off");
  a_rx_block_cause: assert property ($rose(rx_block_o[0]) |-> $past(rx_bytes_vld_i[0], 2)) else $error("receive block without bytes");
  c_warm: cover property (warm_start_o);
  c_rx_block: cover property (rx_block_o[0]);
  c_pause: cover property (pause_o[1]);
  c_ext_pass: cover property (ext_pass_o);
endmodule
bind ptpu_policy ptpu_checker #(.INTERVAL_CYC(INTERVAL_CYC)) CHECKER (.*);

// *** sim/test_port_traffic_policy_unit.sv ***
// self-checking bench for the port traffic policy unit
// assumes ptpu_regs.vh on the include path; inputs change at the falling edge
`timescale 1ns/1ps
`include "ptpu_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_port_traffic_policy_unit;
  logic clk_i = 1'b0, rst_i = 1'b1, restart_i = 1'b0, p_go = 1'b0, rxv_d = 1'b0;
  logic sav_ext_tag_req_i = 1'b0, sav_tag_a_i = 1'b0, sav_tag_data_i = 1'b0, sav_rate_en_i = 1'b0;
  logic sav_global_pause_i = 1'b0, ext_frm_valid_i = 1'b0, ext_frm_tagged_i = 1'b0;
  logic frm_valid_i = 1'b0;
  logic [2:0] sav_vlan_mode_i = 3'h0, sav_link_loss_sel_i = 3'h0, sav_loopback_i = 3'h0;
  logic [2:0] sav_prio_thresh_i = 3'h4, frm_prio_i = 3'h0;
  logic [11:0] sav_mgmt_vid_i = 12'h0, ext_frm_vid_i = 12'h0;
  logic [13:0] sav_max_frame_i = `PTPU_FRAME_MIN, frm_len_i = 14'h0, rx_bytes_d_i = 14'h0;
  logic [13:0] tx_bytes_a_i = 14'h0, tx_bytes_d_i = 14'h0, p_sz = 14'h0;
  logic [7:0] sav_boot_delay_i = 8'h0;
  logic [31:0] sav_rx_lim_a_i = 32'h0, sav_rx_lim_d_i = 32'h0;
  logic [31:0] sav_tx_lim_a_i = 32'h0, sav_tx_lim_d_i = 32'h0;
  logic [1:0] tx_bytes_vld_i = 2'h0, tx_buf_near_full_i = 2'h0, port_pause_allow_i = 2'h0;
  logic [3:0] lbx [8] = '{4'h0, 4'h8, 4'hc, 4'he, 4'h1, 4'h0, 4'h0, 4'h0};
  int fails = 0, total_checks = 0, n;
  wire p_vld;
  wire [13:0] rx_bytes_a_i;
  wire [1:0] rx_bytes_vld_i = {rxv_d, p_vld};
  wire ext_pass_o, ext_insert_tag_o, mgmt_on_data_ports_o, data_vlan_map_en_o, frm_high_prio_o;
  wire frm_too_long_o, remote_fault_en_o, fiber_loss_prop_en_o, copper_loss_prop_en_o, loop_en_o;
  wire loop_swap_o, loop_clear_mc_o, learn_dis_o, warm_start_o;
  wire [11:0] ext_vid_o;
  wire [1:0] rx_block_o, tx_block_o, pause_o;
  // short interval keeps the one-second windows within a brief run
  ptpu_policy #(.INTERVAL_CYC(32'h64)) DUT (.*);
  ptpu_partner PARTNER (.clk_i(clk_i), .go_i(p_go), .size_i(p_sz), .vld_o(p_vld),
    .bytes_o(rx_bytes_a_i));
  always #50 clk_i = ~clk_i;
  task conclude;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // restart pulse; the warm notice lands two edges later when no delay is set
  task restart;
    @(negedge clk_i) restart_i = 1'b1;
    @(negedge clk_i) restart_i = 1'b0;
    @(negedge clk_i) `CHK("warm", sav_boot_delay_i == 8'h0, warm_start_o)
  endtask
  task ext(input logic t, input logic [11:0] v, input logic ep, input logic et);
    @(negedge clk_i) begin ext_frm_valid_i = 1'b1; ext_frm_tagged_i = t; ext_frm_vid_i = v; end
    @(negedge clk_i) ext_frm_valid_i = 1'b0;
    `CHK("ext_pass", ep, ext_pass_o) `CHK("ext_tag", et, ext_insert_tag_o)
  endtask
  task frm(input logic [2:0] p, input logic [13:0] l, input logic eh, input logic el);
    @(negedge clk_i) begin frm_valid_i = 1'b1; frm_prio_i = p; frm_len_i = l; end
    @(negedge clk_i) frm_valid_i = 1'b0;
    `CHK("high_prio", eh, frm_high_prio_o) `CHK("too_long", el, frm_too_long_o)
  endtask
  // partner strobe on port a, then wait until the block decision has landed
  task psend(input logic [13:0] s);
    @(negedge clk_i) begin p_go <= 1'b1; p_sz <= s; end
    @(negedge clk_i) p_go <= 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("warm_idle", 1'b0, warm_start_o)
    for (int i = 0; i < 8; i++) begin
      sav_link_loss_sel_i = i[2:0];
      sav_loopback_i = i[2:0];
      restart();
      `CHK("link", i[2:0], {copper_loss_prop_en_o, fiber_loss_prop_en_o, remote_fault_en_o})
      `CHK("loop", lbx[i], {loop_en_o, loop_swap_o, loop_clear_mc_o, learn_dis_o})
    end
    frm(3'h3, `PTPU_FRAME_MIN, 1'b0, 1'b0);
    frm(3'h4, `PTPU_FRAME_MIN + 14'h1, 1'b1, 1'b1);
    sav_vlan_mode_i = 3'h1; sav_mgmt_vid_i = 12'h0c8; sav_tag_a_i = 1'b1; sav_tag_data_i = 1'b1;
    restart();
    `CHK("mgmt_on", 1'b1, mgmt_on_data_ports_o) `CHK("map", 1'b1, data_vlan_map_en_o)
    ext(1'b0, 12'h0, 1'b1, 1'b1);
    `CHK("ext_vid", 12'h0c8, ext_vid_o)
    sav_ext_tag_req_i = 1'b1; sav_tag_data_i = 1'b0; sav_prio_thresh_i = 3'h3;
    sav_max_frame_i = `PTPU_FRAME_MAX;
    ext(1'b0, 12'h0, 1'b1, 1'b1);
    `CHK("map_held", 1'b1, data_vlan_map_en_o)
    restart();
    `CHK("map_off", 1'b0, data_vlan_map_en_o)
    ext(1'b1, 12'h0c8, 1'b1, 1'b0);
    ext(1'b1, 12'h0c9, 1'b0, 1'b0);
    frm(3'h2, `PTPU_FRAME_MAX, 1'b0, 1'b0);
    frm(3'h3, `PTPU_FRAME_MAX + 14'h1, 1'b1, 1'b1);
    sav_mgmt_vid_i = 12'h0;
    restart();
    `CHK("mgmt_zero", 1'b0, mgmt_on_data_ports_o)
    sav_mgmt_vid_i = 12'h0c8; sav_vlan_mode_i = `PTPU_VMODE_DEFAULT;
    restart();
    `CHK("mgmt_dflt", 1'b0, mgmt_on_data_ports_o)
    ext(1'b1, 12'h0c9, 1'b1, 1'b0);
    // limits on separate directions per port so no port is both policed and shaped
    sav_rate_en_i = 1'b1; sav_rx_lim_a_i = 32'h3e8; sav_tx_lim_d_i = 32'h1f4;
    sav_global_pause_i = 1'b1; port_pause_allow_i = 2'h3;
    restart();
    psend(14'h258);
    `CHK("rx_pause", 1'b1, pause_o[0]) `CHK("rx_open", 1'b0, rx_block_o[0])
    psend(14'h258);
    `CHK("rx_block", 1'b1, rx_block_o[0])
    @(negedge clk_i) begin rxv_d = 1'b1; rx_bytes_d_i = 14'h7d0; tx_bytes_vld_i = 2'h2;
      tx_bytes_d_i = 14'h258; tx_buf_near_full_i = 2'h2; end
    @(negedge clk_i) begin rxv_d = 1'b0; tx_bytes_vld_i = 2'h0; end
    @(negedge clk_i) `CHK("rx_full", 1'b0, rx_block_o[1])
    `CHK("tx_block", 1'b1, tx_block_o[1]) `CHK("tx_pause", 1'b1, pause_o[1])
    for (n = 0; n < 110 && rx_block_o[0] !== 1'b0; n++) @(negedge clk_i);
    `CHK("rx_tick", 1'b0, rx_block_o[0])
    sav_global_pause_i = 1'b0; sav_rate_en_i = 1'b0;
    restart();
    `CHK("pause_gate", 2'h0, pause_o)
    psend(14'h258);
    psend(14'h258);
    `CHK("rate_off", 2'h0, rx_block_o)
    sav_boot_delay_i = 8'h2;
    restart();
    for (n = 0; n < 400 && warm_start_o !== 1'b1; n++) @(negedge clk_i);
    `CHK("warm_delay", 1'b1, n > 150 && n < 260)
    conclude();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule
